//--- cpie_enable_bank.sv
/*
 * Interrupt enable bank for analog comparators 2 and 3, PWM
 * generators 3 and 4 and ADC pairs 2 to 6. Two 16-bit registers
 * gate the raw requests onto registered request outputs.
 * Assumes requests come from logic on ref_clk_in and a simple
 * strobe bus: read data appear the cycle after the read strobe.
 */
// Implementation choices: the register addresses and the strobed register port.
`include "cpie_map.svh"

module cpie_enable_bank #(
   parameter int ADDR_W = 4
) (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [15:0]       wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic [15:0]            rdata_out,
   input  wire logic [1:0]        cmp_req_in,
   input  wire logic [1:0]        pwm_req_in,
   input  wire logic [4:0]        adc_req_in,
   output logic [1:0]             cmp_irq_out,
   output logic [1:0]             pwm_irq_out,
   output logic [4:0]             adc_irq_out
);

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   // Offsets are 4-bit constants, so a narrower address cannot hold them
   if (ADDR_W < 4) begin : g_bad_addr
      $error("cpie_enable_bank: ADDR_W must be at least 4");
   end

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   cpie_pkg::cpie_sel_t sel;

   // Upper address bits must be zero, else the access is unmapped
   always_comb begin
      sel = cpie_pkg::CPIE_SEL_NONE;
      if (addr_in == ADDR_W'(`CPIE_OFF_BANK5)) begin
         sel = cpie_pkg::CPIE_SEL_BANK5;
      end else if (addr_in == ADDR_W'(`CPIE_OFF_BANK6)) begin
         sel = cpie_pkg::CPIE_SEL_BANK6;
      end
   end

   // ------------------------------------------------------------
   // Enable registers
   // ------------------------------------------------------------
   cpie_pkg::cpie_word_t bank5_q;
   cpie_pkg::cpie_word_t bank5_d;
   cpie_pkg::cpie_word_t bank6_q;
   cpie_pkg::cpie_word_t bank6_d;

   // Masking at write time keeps unused bits at zero for good
   always_comb begin
      bank5_d = bank5_q;
      bank6_d = bank6_q;
      if (wr_in && sel == cpie_pkg::CPIE_SEL_BANK5) begin
         bank5_d = wdata_in & `CPIE_B5_MASK;
      end
      if (wr_in && sel == cpie_pkg::CPIE_SEL_BANK6) begin
         bank6_d = wdata_in & `CPIE_B6_MASK;
      end
   end

   // Power-on state: every source blocked
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         bank5_q <= `CPIE_B5_RESET;
         bank6_q <= `CPIE_B6_RESET;
      end else begin
         bank5_q <= bank5_d;
         bank6_q <= bank6_d;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;

   // Data stand for one cycle only; unmapped reads give zero
   always_comb begin
      rdata_d = 16'h0000;
      if (rd_in) begin
         case (sel)
            cpie_pkg::CPIE_SEL_BANK5: begin
               rdata_d = bank5_q & `CPIE_B5_MASK;
            end
            cpie_pkg::CPIE_SEL_BANK6: begin
               rdata_d = bank6_q & `CPIE_B6_MASK;
            end
            default: begin
               rdata_d = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_out = rdata_q;

   // ------------------------------------------------------------
   // Request gating
   // ------------------------------------------------------------
   logic [1:0] cmp_en;
   logic [1:0] pwm_en;
   logic [4:0] adc_en;
   logic [1:0] cmp_irq_d;
   logic [1:0] cmp_irq_q;
   logic [1:0] pwm_irq_d;
   logic [1:0] pwm_irq_q;
   logic [4:0] adc_irq_d;
   logic [4:0] adc_irq_q;

   // Index 0 is comparator 2 / PWM 3, index 1 comparator 3 / PWM 4
   assign cmp_en[0] = bank5_q[`CPIE_B5_CMP2];
   assign cmp_en[1] = bank5_q[`CPIE_B5_CMP3];
   assign pwm_en[0] = bank5_q[`CPIE_B5_PWM3];
   assign pwm_en[1] = bank5_q[`CPIE_B5_PWM4];

   // ADC pair n+2 sits on bank6 bit n
   assign adc_en[4] = bank6_q[`CPIE_B6_PAIR6];
   assign adc_en[3] = bank6_q[`CPIE_B6_PAIR5];
   assign adc_en[2] = bank6_q[`CPIE_B6_PAIR4];
   assign adc_en[1] = bank6_q[`CPIE_B6_PAIR3];
   assign adc_en[0] = bank6_q[`CPIE_B6_PAIR2];

   // Plain AND per source; a one lets the request through
   always_comb begin
      cmp_irq_d = cmp_req_in & cmp_en;
      pwm_irq_d = pwm_req_in & pwm_en;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_adc
         always_comb begin
            adc_irq_d[gi] = adc_req_in[gi] & adc_en[gi];
         end
      end
   endgenerate

   // One cycle of latency buys clean, glitch-free outputs
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cmp_irq_q <= 2'h0;
         pwm_irq_q <= 2'h0;
         adc_irq_q <= 5'h00;
      end else begin
         cmp_irq_q <= cmp_irq_d;
         pwm_irq_q <= pwm_irq_d;
         adc_irq_q <= adc_irq_d;
      end
   end

   assign cmp_irq_out = cmp_irq_q;
   assign pwm_irq_out = pwm_irq_q;
   assign adc_irq_out = adc_irq_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // Single-cycle write and read strobes to each bank
   sequence s_wr_bank6;
      wr_in && addr_in == ADDR_W'(`CPIE_OFF_BANK6);
   endsequence

   sequence s_wr_bank5;
      wr_in && addr_in == ADDR_W'(`CPIE_OFF_BANK5);
   endsequence

   sequence s_rd_bank5;
      rd_in && addr_in == ADDR_W'(`CPIE_OFF_BANK5);
   endsequence

   sequence s_rd_bank6;
      rd_in && addr_in == ADDR_W'(`CPIE_OFF_BANK6);
   endsequence

   a_cmp3_gate: assert property (
      s_wr_bank5 ##1 (cmp_req_in[1] && !wr_in)
      |=> cmp_irq_out[1] == $past(bank5_q[8])
   ) else $error("comparator 3 request not gated by bank5 bit 8");

   a_cmp2_gate: assert property (
      cmp_req_in[0] |=> cmp_irq_out[0] == $past(bank5_q[7])
   ) else $error("comparator 2 request not gated by bank5 bit 7");

   a_blocked_src: assert property (
      (!bank6_q[0] && !bank5_q[1]) |=> (!adc_irq_out[0] && !pwm_irq_out[1])
   ) else $error("disabled source raised a request");

   a_pass_src: assert property (
      (adc_req_in[1] && bank6_q[1]) |=> adc_irq_out[1]
   ) else $error("enabled ADC pair 3 request did not pass");

   a_bank6_write: assert property (
      s_wr_bank6 ##1 s_rd_bank6
      |=> rdata_out == ($past(wdata_in, 2) & 16'h001f)
   ) else $error("bank6 write not returned on read");

   a_adc6_gate: assert property (
      adc_req_in[4] |=> adc_irq_out[4] == $past(bank6_q[4])
   ) else $error("ADC pair 6 not gated by bank6 bit 4");

   a_adc5_gate: assert property (
      adc_req_in[3] |=> adc_irq_out[3] == $past(bank6_q[3])
   ) else $error("ADC pair 5 not gated by bank6 bit 3");

   a_unimpl_zero: assert property (
      s_rd_bank5 |=> (rdata_out & 16'hfe7c) == 16'h0000
   ) else $error("unimplemented bank5 bit read as one");

   a_unimpl_b6: assert property (
      s_wr_bank6 |=> bank6_q[15:5] == 11'h000
   ) else $error("unimplemented bank6 bit took a write");

   a_adc_low: assert property (
      (adc_req_in[2:0] == 3'h7) |=> adc_irq_out[2:0] == $past(bank6_q[2:0])
   ) else $error("ADC pairs 4..2 not gated by bank6 bits 2..0");

   a_pwm_gate: assert property (
      (pwm_req_in == 2'h3) |=> pwm_irq_out == {$past(bank5_q[1]), $past(bank5_q[0])}
   ) else $error("PWM requests not gated by bank5 bits 1,0");

   a_read_once: assert property (
      !rd_in |=> rdata_out == 16'h0000
   ) else $error("read data stood beyond one cycle");

   // Bank5 write seen by a read straight after it
   a_bank5_write: assert property (
      s_wr_bank5 ##1 s_rd_bank5
      |=> rdata_out == ($past(wdata_in, 2) & `CPIE_B5_MASK)
   ) else $error("bank5 write not returned on read");

   // Write-time masking must clear every unused bank5 bit
   a_unimpl_b5: assert property (
      s_wr_bank5 |=> (bank5_q & 16'hfe7c) == 16'h0000
   ) else $error("unimplemented bank5 bit took a write");

   // Upper bank6 bits read as zero
   a_b6_rd_high: assert property (
      s_rd_bank6 |=> rdata_out[15:5] == 11'h000
   ) else $error("unimplemented bank6 bit read as one");

   // Comparator 3 stays quiet while its enable is clear
   a_cmp3_block: assert property (
      !bank5_q[8] |=> !cmp_irq_out[1]
   ) else $error("comparator 3 request passed while disabled");

   // Comparator 2 stays quiet while its enable is clear
   a_cmp2_block: assert property (
      !bank5_q[7] |=> !cmp_irq_out[0]
   ) else $error("comparator 2 request passed while disabled");

   // Both PWM outputs quiet with both enables clear
   a_pwm_block: assert property (
      bank5_q[1:0] == 2'h0 |=> pwm_irq_out == 2'h0
   ) else $error("PWM request passed while disabled");

   // Enabled PWM 4 request must get through
   a_pwm4_pass: assert property (
      (pwm_req_in[1] && bank5_q[1]) |=> pwm_irq_out[1]
   ) else $error("enabled PWM 4 request did not pass");

   // No request in, no request out, whatever the enables
   a_idle_quiet: assert property (
      (cmp_req_in == 2'h0 && pwm_req_in == 2'h0 && adc_req_in == 5'h00)
      |=> (cmp_irq_out == 2'h0 && pwm_irq_out == 2'h0 && adc_irq_out == 5'h00)
   ) else $error("request raised with no source active");

   // Enables change only on a write strobe
   a_bank_hold: assert property (
      !wr_in |=> ($stable(bank5_q) && $stable(bank6_q))
   ) else $error("enable register changed without a write");

endmodule

//--- cpie_map.svh
/*
 * Register offsets, bit positions and reset values of the
 * comparator, PWM and ADC interrupt enable bank.
 * Assumes a 4-bit register address and 16-bit data.
 */
`ifndef CPIE_MAP_SVH
`define CPIE_MAP_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define CPIE_OFF_BANK5      4'h0
`define CPIE_OFF_BANK6      4'h2

// ------------------------------------------------------------
// Bank 5 fields
// ------------------------------------------------------------
`define CPIE_B5_CMP3        8
`define CPIE_B5_CMP2        7
`define CPIE_B5_PWM4        1
`define CPIE_B5_PWM3        0
`define CPIE_B5_MASK        16'h0183

// ------------------------------------------------------------
// Bank 6 fields
// ------------------------------------------------------------
`define CPIE_B6_PAIR6       4
`define CPIE_B6_PAIR5       3
`define CPIE_B6_PAIR4       2
`define CPIE_B6_PAIR3       1
`define CPIE_B6_PAIR2       0
`define CPIE_B6_MASK        16'h001f

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CPIE_B5_RESET       16'h0000
`define CPIE_B6_RESET       16'h0000

`endif

//--- cpie_pkg.sv
/*
 * Types shared by the interrupt enable bank.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
package cpie_pkg;

   // ------------------------------------------------------------
   // Register word and decoded selection
   // ------------------------------------------------------------
   typedef logic [15:0] cpie_word_t;

   typedef enum logic [1:0] {
      CPIE_SEL_NONE,
      CPIE_SEL_BANK5,
      CPIE_SEL_BANK6
   } cpie_sel_t;

endpackage

//--- tb_top.sv
/*
 * Self-checking bench for the comparator, PWM and ADC interrupt
 * enable bank: register access, unused bits, unmapped addresses
 * and the gating of each request by its enable.
 * Assumes the design checks its own port timing with assertions.
 */
`include "cpie_map.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals and design instance
   // ------------------------------------------------------------
   logic                ref_clk_in;
   logic                rst_in;
   logic [3:0]          addr_in;
   logic [15:0]         wdata_in;
   logic                wr_in;
   logic                rd_in;
   logic [15:0]         rdata_out;
   logic [1:0]          cmp_req_in;
   logic [1:0]          pwm_req_in;
   logic [4:0]          adc_req_in;
   logic [1:0]          cmp_irq_out;
   logic [1:0]          pwm_irq_out;
   logic [4:0]          adc_irq_out;
   int                  num_errors;
   int                  check_count;
   cpie_pkg::cpie_word_t v;
   logic [8:0]          en;

   cpie_enable_bank #(.ADDR_W(4)) uut (
      .ref_clk_in (ref_clk_in), .rst_in (rst_in), .addr_in (addr_in),
      .wdata_in (wdata_in), .wr_in (wr_in), .rd_in (rd_in),
      .rdata_out (rdata_out), .cmp_req_in (cmp_req_in),
      .pwm_req_in (pwm_req_in), .adc_req_in (adc_req_in),
      .cmp_irq_out (cmp_irq_out), .pwm_irq_out (pwm_irq_out),
      .adc_irq_out (adc_irq_out)
   );

   // Clock at 25 MHz
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   // ------------------------------------------------------------
   // Tasks: wr_reg, rd_reg and req_chk start and end right at a rising edge
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe stays high: the next step lowers it, so writes chain cleanly
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge ref_clk_in);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      wr_in   <= 1'b0;
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge ref_clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
      @(posedge ref_clk_in);
   endtask

   // Requests sampled at one edge show on the outputs after it
   task automatic req_chk(input logic [8:0] r, input logic [8:0] exp);
      wr_in      <= 1'b0;
      pwm_req_in <= r[1:0];
      cmp_req_in <= r[3:2];
      adc_req_in <= r[8:4];
      @(posedge ref_clk_in);
      #1 check({7'h0, adc_irq_out, cmp_irq_out, pwm_irq_out}, {7'h0, exp});
      @(posedge ref_clk_in);
   endtask

   task automatic give_verdict;
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watchdog: the tests need well under 1000 cycles
   // ------------------------------------------------------------
   initial begin
      #200us;
      num_errors++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      num_errors = 0;
      check_count = 0;
      rst_in = 1'b1;
      addr_in = 4'h0;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      {cmp_req_in, pwm_req_in, adc_req_in} = 9'h000;
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      // Reset values of both banks
      rd_reg(`CPIE_OFF_BANK5, v); check(v, `CPIE_B5_RESET);
      rd_reg(`CPIE_OFF_BANK6, v); check(v, `CPIE_B6_RESET);
      // All ones: only implemented bits stick, read straight after write
      wr_reg(`CPIE_OFF_BANK5, 16'hffff);
      rd_reg(`CPIE_OFF_BANK5, v); check(v, 16'h0183);
      #1 check(rdata_out, 16'h0000);
      @(posedge ref_clk_in);
      wr_reg(`CPIE_OFF_BANK6, 16'hffff);
      rd_reg(`CPIE_OFF_BANK6, v); check(v, 16'h001f);
      // Unmapped addresses ignore writes and read zero
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'hf, 16'h0000);
      rd_reg(4'h1, v); check(v, 16'h0000);
      rd_reg(`CPIE_OFF_BANK5, v); check(v, 16'h0183);
      // Each enable alone, all requests high, then all low
      for (int i = 0; i < 9; i++) begin
         en = 9'h001 << i;
         wr_reg(`CPIE_OFF_BANK5, {7'h00, en[3], en[2], 5'h00, en[1], en[0]});
         wr_reg(`CPIE_OFF_BANK6, {11'h000, en[8:4]});
         rd_reg(`CPIE_OFF_BANK6, v); check(v, {11'h000, en[8:4]});
         req_chk(9'h1ff, en);
         req_chk(9'h000, 9'h000);
      end
      // Request raised right after a write: the new enable governs it
      wr_reg(`CPIE_OFF_BANK5, 16'h0100);
      req_chk(9'h008, 9'h008);
      // Enables all on: each output follows its own request only
      wr_reg(`CPIE_OFF_BANK5, 16'h0183);
      wr_reg(`CPIE_OFF_BANK6, 16'h001f);
      req_chk(9'h155, 9'h155);
      req_chk(9'h0aa, 9'h0aa);
      // Clearing an enable blocks a request that is still held
      wr_reg(`CPIE_OFF_BANK6, 16'h0000);
      wr_in <= 1'b0;
      #1 check({11'h000, adc_irq_out}, 16'h000a);
      @(posedge ref_clk_in);
      #1 check({11'h000, adc_irq_out}, 16'h0000);
      @(posedge ref_clk_in);
      give_verdict();
   end
endmodule
